/* bench/ring_link_central_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module ring_link_central_control_tb;
  logic        mclk_i = 0, reset_i = 1, wr_i = 0, rd_i = 0;
  logic        peer_valid_i = 0, task_start_i = 0;
  logic        blocks_done_i = 0, base_tick_i = 0;
  logic [7:0]  addr_i = 0, peer_hwa_i = 0;
  logic [31:0] wdata_i = 0, rdata_o, tx_data_o, d;
  logic        sync_rx_i, ring_up_i, cycle_end_i, overrun_i, timeout_i;
  logic        crc_err_i, tx_ready_i, irq_task_o, cycle_start_o;
  logic        init_seq_o, gap_fill_enable_o, link_run_o;
  logic        group_error_flag_o, tx_valid_o;
  logic [7:0]  ring_nodes_i, ring_faulty_i, node_addr_o, nd, hw;
  logic [2:0]  op_mode_select_o;
  logic [1:0]  tx_power_o, pw, s;
  logic [31:0] q[$];
  logic [31:0] bad[5], rx[6];
  int          mismatches = 0, tests_run = 0, n, i;
  rlc_central #(.STARTUP_CYC(20), .TX_DEPTH(32)) rlc_central_i (
    .mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .peer_valid_i(peer_valid_i), .peer_hwa_i(peer_hwa_i),
    .task_start_i(task_start_i), .blocks_done_i(blocks_done_i),
    .base_tick_i(base_tick_i), .sync_rx_i(sync_rx_i),
    .ring_up_i(ring_up_i), .cycle_end_i(cycle_end_i),
    .overrun_i(overrun_i), .timeout_i(timeout_i), .crc_err_i(crc_err_i),
    .ring_nodes_i(ring_nodes_i), .ring_faulty_i(ring_faulty_i),
    .irq_task_o(irq_task_o), .cycle_start_o(cycle_start_o),
    .init_seq_o(init_seq_o), .op_mode_select_o(op_mode_select_o),
    .node_addr_o(node_addr_o), .tx_power_o(tx_power_o),
    .gap_fill_enable_o(gap_fill_enable_o), .link_run_o(link_run_o),
    .group_error_flag_o(group_error_flag_o), .tx_valid_o(tx_valid_o),
    .tx_ready_i(tx_ready_i), .tx_data_o(tx_data_o));
  rlc_ring_model rlc_ring_model_i (.mclk_i(mclk_i), .sync_rx_o(sync_rx_i),
    .ring_up_o(ring_up_i), .cycle_end_o(cycle_end_i),
    .overrun_o(overrun_i), .timeout_o(timeout_i), .crc_err_o(crc_err_i),
    .nodes_o(ring_nodes_i), .faulty_o(ring_faulty_i),
    .tx_ready_o(tx_ready_i));
  initial begin
    forever #20 mclk_i = ~mclk_i;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rst();
    @(posedge mclk_i);
    reset_i <= 1'b1;
    peer_valid_i <= 1'b0;
    repeat (6) @(posedge mclk_i);
    reset_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  // Bounded wait on init pulse (w=0) or run level (w=1)
  task automatic wt(input int w, input int lim);
    int k;
    for (k = 0; k < lim; k++) begin
      @(posedge mclk_i);
      #1;
      if ((w ? link_run_o : init_seq_o) === 1'b1) break;
    end
    if (k == lim) begin
      chk("wait", 0, 1);
      test_done();
    end
  endtask
  function automatic logic [31:0] cw(input int m, input logic [7:0] nn,
    input logic [1:0] p, input logic [7:0] h, input logic st);
    return {8'h00, h, nn, 1'b0, p, m[0], st, m[2:0]};
  endfunction
  // Expected {interrupt, cycle start}; k: 0 sync, 1 blocks, 2 base tick
  function automatic logic [1:0] ex(input int m, input int k);
    if (k == 0) return (m == 3) ? 2'b11 : (m == 0 || m == 4) ? 2'b10 : 2'b00;
    if (k == 1) return (m == 1 || m == 2) ? 2'b01 : 2'b00;
    return (m == 4 || m == 5) ? 2'b01 : 2'b00;
  endfunction
  task automatic ev(input int k);
    if (k == 0) begin
      rlc_ring_model_i.pulse(0, 8'h00);
    end else begin
      @(posedge mclk_i);
      blocks_done_i <= (k == 1);
      task_start_i <= (k == 1);
      base_tick_i <= (k == 2);
      @(posedge mclk_i);
      {blocks_done_i, task_start_i, base_tick_i} <= 3'b000;
    end
    s = 2'b00;
    repeat (3) begin
      #1 s = s | {irq_task_o, cycle_start_o};
      @(posedge mclk_i);
    end
  endtask
  always @(posedge mclk_i) begin
    if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
      if (q.size() == 0) chk("tx_extra", 0, 1);
      else chk("tx_data", q.pop_front(), tx_data_o);
    end
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(82));
    bad = '{cw(6, 1, 1, 1, 1), cw(0, 1, 1, 0, 1), cw(0, 201, 1, 1, 1),
      cw(0, 1, 0, 1, 1), cw(0, 1, 1, 5, 1)};
    rst();
    rd(8'h24);
    chk("timer_rst", 32'h3e8, d);
    rd(8'h40);
    chk("unmapped", 0, d);
    // Bad configurations, last one a second controller on the same address
    for (i = 0; i < 5; i++) begin
      rst();
      peer_valid_i <= (i == 4);
      peer_hwa_i <= 8'h05;
      wr(8'h00, bad[i]);
      repeat (6) @(posedge mclk_i);
      rd(8'h04);
      chk("err_cfg", (i == 4) ? 2 : 1, d & 32'h3f);
      chk("flag", 1, group_error_flag_o);
    end
    rst();
    wr(8'h00, cw(1, 0, 1, 3, 1));
    wt(0, 20);
    repeat (30) @(posedge mclk_i);
    rd(8'h04);
    chk("startup_tmo", 4, d & 32'h3f);
    for (int m = 0; m < 6; m++) begin
      rst();
      nd = (m == 0) ? 8'(1 + $urandom % 200) : 8'(201 + $urandom % 55);
      pw = 2'(1 + $urandom % 3);
      hw = 8'(1 + $urandom % 255);
      if (m == 0) begin
        for (i = 0; i < 33; i++) begin
          d = $urandom;
          wr(8'h20, d);
          if (i < 32) q.push_back(d);
        end
        rd(8'h04);
        chk("fifo_full", 1, d[11]);
      end
      wr(8'h00, cw(m, nd, pw, hw, 1));
      wt(0, 20);
      chk("mode", m, op_mode_select_o);
      chk("node", (m == 0) ? nd : 0, node_addr_o);
      chk("power", pw, tx_power_o);
      chk("fill", m % 2, gap_fill_enable_o);
      rd(8'h00);
      chk("ctrl_rd", cw(m, nd, pw, hw, 0), d);
      rlc_ring_model_i.pulse(1, 8'h00);
      wt(1, 10);
      for (int k = 0; k < 3; k++) begin
        ev(k);
        chk("events", ex(m, k), s);
      end
      if (m == 2) begin
        wr(8'h24, 5);
        n = 0;
        repeat (20) begin
          @(posedge mclk_i);
          #1 if (irq_task_o === 1'b1) n++;
        end
        chk("timer_irq", 1, n >= 3 && n <= 5);
      end
      if (m == 0) begin
        rlc_ring_model_i.pulse(3, 8'h00);
        rlc_ring_model_i.pulse(4, 8'h07);
        rlc_ring_model_i.pulse(5, 8'h07);
        rlc_ring_model_i.pulse(2, 8'd12);
        rlc_ring_model_i.pulse(2, 8'd12);
        rx = '{{16'h0000, nd, 8'd12}, 2, 1, 1, 1, 7};
        for (i = 0; i < 6; i++) begin
          rd(8'(8 + 4 * i));
          chk("link_info", rx[i], d);
        end
        rd(8'h04);
        chk("err_run", 32'h38, d & 32'h3f);
        chk("flag_run", 1, group_error_flag_o);
        wr(8'h00, cw(0, nd - 8'h01, 2'(pw % 3 + 1), hw, 0));
        repeat (3) @(posedge mclk_i);
        chk("node_held", nd, node_addr_o);
        chk("power_held", pw, tx_power_o);
        for (i = 0; i < 300 && q.size() > 0; i++) @(posedge mclk_i);
        chk("drained", 0, q.size());
        wr(8'h00, cw(0, nd - 8'h01, 2'(pw % 3 + 1), hw, 1));
        wt(0, 20);
        chk("node_new", nd - 8'h01, node_addr_o);
        chk("power_new", 2'(pw % 3 + 1), tx_power_o);
        rd(8'h0c);
        chk("cycles_clr", 0, d);
        rd(8'h04);
        chk("fifo_empty", 0, d[12]);
      end
    end
    test_done();
  end
endmodule
`default_nettype wire

/* bench/rlc_ring_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rlc_ring_model (
  input  wire logic       mclk_i,
  output logic            sync_rx_o,
  output logic            ring_up_o,
  output logic            cycle_end_o,
  output logic            overrun_o,
  output logic            timeout_o,
  output logic            crc_err_o,
  output logic      [7:0] nodes_o,
  output logic      [7:0] faulty_o,
  output logic            tx_ready_o
);
  logic [5:0] ev_q;
  initial begin
    ev_q = 6'h00;
    nodes_o = 8'h00;
    faulty_o = 8'h00;
    tx_ready_o = 1'b0;
  end
  assign {crc_err_o, timeout_o, overrun_o} = ev_q[5:3];
  assign {cycle_end_o, ring_up_o, sync_rx_o} = ev_q[2:0];
  //////////////////////////////////////////////////////////////////////////
  // One ring event per call; values go stale right after their cycle
  task automatic pulse(input int k, input logic [7:0] v);
    @(posedge mclk_i);
    ev_q[k] <= 1'b1;
    nodes_o <= v;
    faulty_o <= v;
    @(posedge mclk_i);
    ev_q <= 6'h00;
    nodes_o <= ~v;
    faulty_o <= ~v;
  endtask
  // Random stalls so the stream sees back-pressure
  always @(posedge mclk_i) tx_ready_o <= ($urandom % 3) != 0;
endmodule
`default_nettype wire

/* verilog/rlc_central.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rlc_regs.svh"
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Six operating modes chosen by mode field, each with own timing.
// - Mode 0 slave: every received sync telegram raises task interrupt.
// - Slave mode: host reads values and fills transmit buffer per interrupt.
// - Mode 1 master: telegrams sent only after last block computation.
// - Mode 2 master: own timer raises interrupt; send after computation.
// - Node address used only in slave mode, ignored in master modes.
// - Node address and power changes apply only at link restart.
// - Initialisation checks every configuration value is in range.
// - Initialisation flags a second controller on same board address.
// - After config, send ring init sequence and supervise start-up.
// - In run, monitor ring and flag communication faults.
// - In run, report node, cycle, overrun, timeout, CRC, faulty node, flag.
// - Mode 3 master: each sync restarts ring cycle and raises interrupt.
// - Mode 4: base clock starts sending; next sync raises interrupt.
// - Mode 5: base clock starts each ring cycle, blocks in base period.
module rlc_central #(
  parameter int STARTUP_CYC = `RLC_STARTUP_US * `RLC_MCLK_MHZ,
  parameter int TX_DEPTH    = 32
) (
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  input  wire logic        peer_valid_i,
  input  wire logic [7:0]  peer_hwa_i,
  input  wire logic        task_start_i,
  input  wire logic        blocks_done_i,
  input  wire logic        base_tick_i,
  input  wire logic        sync_rx_i,
  input  wire logic        ring_up_i,
  input  wire logic        cycle_end_i,
  input  wire logic        overrun_i,
  input  wire logic        timeout_i,
  input  wire logic        crc_err_i,
  input  wire logic [7:0]  ring_nodes_i,
  input  wire logic [7:0]  ring_faulty_i,
  output logic             irq_task_o,
  output logic             cycle_start_o,
  output logic             init_seq_o,
  output logic      [2:0]  op_mode_select_o,
  output logic      [7:0]  node_addr_o,
  output logic      [1:0]  tx_power_o,
  output logic             gap_fill_enable_o,
  output logic             link_run_o,
  output logic             group_error_flag_o,
  output logic             tx_valid_o,
  input  wire logic        tx_ready_i,
  output logic      [31:0] tx_data_o
);
  import rlc_pkg::*;

  rlc_ctl_t s_q, s_d;
  logic     fifo_in_ready;
  logic     fifo_out_valid;
  logic     timer_tick;
  logic     run;
  logic     start_req;
  logic     push_req;
  logic     range_ok;

  //////////////////////////////////////////////////////////////////////////
  // Transmit buffer and equivalent sampling timer
  assign run       = (s_q.st == RLC_ST_RUN);
  assign push_req  = wr_i && (addr_i == `RLC_OFF_TXDATA);
  assign start_req = wr_i && (addr_i == `RLC_OFF_CTRL) &&
                     wdata_i[`RLC_CTRL_START];

  rlc_fifo #(
    .WIDTH (32),
    .DEPTH (TX_DEPTH)
  ) u_txbuf (
    .mclk_i      (mclk_i),
    .reset_i     (reset_i),
    .in_valid_i  (push_req),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (wdata_i),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (tx_ready_i && run),
    .out_data_o  (tx_data_o)
  );
  // Draining only in run keeps queued words for the first live cycle
  assign tx_valid_o = fifo_out_valid && run;

  // timer runs only in timer mode
  rlc_timer #(
    .WIDTH (16)
  ) u_timer (
    .mclk_i   (mclk_i),
    .reset_i  (reset_i),
    .run_i    (run && (s_q.mode == RLC_MD_TIMER)),
    .period_i (s_q.timer_per),
    .tick_o   (timer_tick)
  );

  //////////////////////////////////////////////////////////////////////////
  // Range check of the configuration before it is applied
  // value range check
  always_comb begin
    range_ok = (s_q.mode < `RLC_MODE_COUNT) &&
               (s_q.pend_pow >= `RLC_POW_MIN) &&
               (s_q.hwa != 8'h00);
    if (s_q.mode == RLC_MD_SLAVE) begin
      range_ok = range_ok && (s_q.pend_node <= `RLC_NODE_MAX);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Control, sequencing and monitoring
  always_comb begin
    s_d = s_q;
    s_d.irq = 1'b0;
    s_d.cyc_start = 1'b0;
    s_d.init_seq = 1'b0;
    s_d.rdata = 32'h0000_0000;
    // Register writes
    if (wr_i && (addr_i == `RLC_OFF_CTRL)) begin
      // new address and power held pending
      s_d.pend_node = wdata_i[`RLC_CTRL_NODE_LSB +: 8];
      s_d.pend_pow  = wdata_i[`RLC_CTRL_POW_LSB +: 2];
      s_d.fill      = wdata_i[`RLC_CTRL_FILL];
      // Mode and board address only change while the link is down
      if (!run) begin
        s_d.mode = rlc_mode_t'(wdata_i[`RLC_CTRL_MODE_LSB +: 3]);
        s_d.hwa  = wdata_i[`RLC_CTRL_HWA_LSB +: 8];
      end
    end else if (wr_i && (addr_i == `RLC_OFF_TIMER)) begin
      s_d.timer_per = wdata_i[15:0];
    end
    // Register reads
    if (rd_i && (addr_i == `RLC_OFF_CTRL)) begin
      s_d.rdata = {8'h00, s_q.hwa, s_q.pend_node, 1'b0, s_q.pend_pow,
                   s_q.fill, 1'b0, s_q.mode};
    end else if (rd_i && (addr_i == `RLC_OFF_STATUS)) begin
      s_d.rdata = {16'h0000, 3'h0, fifo_out_valid, !fifo_in_ready,
                   s_q.st, 2'h0, s_q.err};
    end else if (rd_i && (addr_i == `RLC_OFF_NODES)) begin
      s_d.rdata = {16'h0000, s_q.node, s_q.nodes};
    end else if (rd_i && (addr_i == `RLC_OFF_CYCLES)) begin
      s_d.rdata = s_q.cycles;
    end else if (rd_i && (addr_i == `RLC_OFF_OVERRUN)) begin
      s_d.rdata = s_q.overruns;
    end else if (rd_i && (addr_i == `RLC_OFF_TIMEOUT)) begin
      s_d.rdata = s_q.timeouts;
    end else if (rd_i && (addr_i == `RLC_OFF_CRC)) begin
      s_d.rdata = s_q.crcs;
    end else if (rd_i && (addr_i == `RLC_OFF_FAULTY)) begin
      s_d.rdata = {24'h000000, s_q.faulty};
    end else if (rd_i && (addr_i == `RLC_OFF_TIMER)) begin
      s_d.rdata = {16'h0000, s_q.timer_per};
    end
    // Sequencer
    case (s_q.st)
      RLC_ST_IDLE, RLC_ST_RUN, RLC_ST_FAULT: begin
        if (start_req) begin
          s_d.err      = '0;
          s_d.cycles   = '0;
          s_d.overruns = '0;
          s_d.timeouts = '0;
          s_d.crcs     = '0;
          s_d.nodes    = '0;
          s_d.faulty   = '0;
          s_d.st       = RLC_ST_CHECK;
        end
      end
      RLC_ST_CHECK: begin
        if (!range_ok) begin
          s_d.err[`RLC_ERR_RANGE] = 1'b1;
          s_d.st = RLC_ST_FAULT;
        end else if (peer_valid_i && (peer_hwa_i == s_q.hwa)) begin
          s_d.err[`RLC_ERR_DUP] = 1'b1;
          s_d.st = RLC_ST_FAULT;
        end else begin
          s_d.st = RLC_ST_CONFIG;
        end
      end
      RLC_ST_CONFIG: begin
        s_d.tx_power = s_q.pend_pow;
        s_d.node = (s_q.mode == RLC_MD_SLAVE) ? s_q.pend_node : 8'h00;
        s_d.st = RLC_ST_INITSEQ;
      end
      RLC_ST_INITSEQ: begin
        s_d.init_seq = 1'b1;
        s_d.wait_cnt = '0;
        s_d.st = RLC_ST_STARTUP;
      end
      RLC_ST_STARTUP: begin
        if (ring_up_i) begin
          s_d.st = RLC_ST_RUN;
        end else if (s_q.wait_cnt >= 20'(STARTUP_CYC - 1)) begin
          s_d.err[`RLC_ERR_START] = 1'b1;
          s_d.st = RLC_ST_FAULT;
        end else begin
          s_d.wait_cnt = s_q.wait_cnt + 1'b1;
        end
      end
      default: begin
        s_d.st = RLC_ST_IDLE;
      end
    endcase
    // Run-time timing and monitoring; a restart request takes priority
    if (run && !start_req) begin
      case (s_q.mode)
        RLC_MD_SLAVE: begin
          s_d.irq = sync_rx_i;
        end
        RLC_MD_ASYNC: begin
          s_d.cyc_start = blocks_done_i;
        end
        RLC_MD_TIMER: begin
          s_d.irq = timer_tick;
          s_d.cyc_start = blocks_done_i;
        end
        RLC_MD_AUTO: begin
          s_d.irq = sync_rx_i;
          s_d.cyc_start = sync_rx_i;
        end
        RLC_MD_EXTERNAL: begin
          s_d.irq = sync_rx_i;
          s_d.cyc_start = base_tick_i;
        end
        RLC_MD_EXTCYC: begin
          s_d.cyc_start = base_tick_i;
        end
        default: begin
          s_d.irq = 1'b0;
        end
      endcase
      // fault flags stay set until next initialisation
      if (timeout_i) begin
        s_d.err[`RLC_ERR_TMO] = 1'b1;
        s_d.timeouts = s_q.timeouts + 1'b1;
      end
      if (crc_err_i) begin
        s_d.err[`RLC_ERR_CRC] = 1'b1;
        s_d.crcs = s_q.crcs + 1'b1;
      end
      if (overrun_i) begin
        s_d.err[`RLC_ERR_OVR] = 1'b1;
        s_d.overruns = s_q.overruns + 1'b1;
      end
      if (cycle_end_i) begin
        s_d.cycles = s_q.cycles + 1'b1;
        s_d.nodes  = ring_nodes_i;
      end
      if (timeout_i || crc_err_i) begin
        s_d.faulty = ring_faulty_i;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      s_q <= '0;
      s_q.timer_per <= `RLC_TIMER_RST;
      s_q.pend_pow <= `RLC_POW_MIN;
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  assign rdata_o            = s_q.rdata;
  assign irq_task_o         = s_q.irq;
  assign cycle_start_o      = s_q.cyc_start;
  assign init_seq_o         = s_q.init_seq;
  assign op_mode_select_o   = s_q.mode;
  assign node_addr_o        = s_q.node;
  assign tx_power_o         = s_q.tx_power;
  assign gap_fill_enable_o  = s_q.fill;
  assign link_run_o         = run;
  assign group_error_flag_o = |s_q.err;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  chk_slave_sync_irq: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    (run && s_q.mode == RLC_MD_SLAVE && sync_rx_i && !start_req)
      |=> irq_task_o)
    else $error("slave sync did not raise interrupt");
  chk_async_tx_gate: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    (s_q.mode == RLC_MD_ASYNC && cycle_start_o) |-> $past(blocks_done_i))
    else $error("async cycle start without finished blocks");
  chk_timer_irq_src: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    (s_q.mode == RLC_MD_TIMER && irq_task_o) |-> $past(timer_tick))
    else $error("timer mode interrupt without timer tick");
  chk_master_node_zero: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    (run && s_q.mode != RLC_MD_SLAVE) |-> (node_addr_o == 8'h00))
    else $error("master mode uses node address");
  chk_pend_hold_run: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    (run && $past(run)) |-> $stable(tx_power_o) && $stable(node_addr_o))
    else $error("power or address changed during run");
  chk_range_fault: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    (s_q.st == RLC_ST_CHECK && !range_ok)
      |=> (s_q.st == RLC_ST_FAULT) && s_q.err[`RLC_ERR_RANGE])
    else $error("range error not flagged");
  chk_dup_addr_flag: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    (s_q.st == RLC_ST_CHECK && range_ok && peer_valid_i &&
     peer_hwa_i == s_q.hwa) |=> s_q.err[`RLC_ERR_DUP])
    else $error("duplicate board address not flagged");
  chk_init_then_wait: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    (s_q.st == RLC_ST_CONFIG)
      |=> (s_q.st == RLC_ST_INITSEQ) ##1
          (init_seq_o && s_q.st == RLC_ST_STARTUP))
    else $error("init sequence not followed by start-up wait");
  chk_crc_count_up: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    (run && crc_err_i && !start_req)
      |=> (s_q.crcs == $past(s_q.crcs) + 32'h1) && group_error_flag_o)
    else $error("crc error not counted or flagged");
endmodule
`default_nettype wire

/* verilog/rlc_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module rlc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input  wire logic             mclk_i,
  input  wire logic             reset_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } rlc_fifo_st_t;

  rlc_fifo_st_t s_q, s_d;
  logic push, pop;

  // Count is one bit wider than the pointers so full stays distinct from 0
  assign in_ready_o  = (s_q.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (s_q.cnt != '0);
  assign out_data_o  = s_q.mem[s_q.rp];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_data_i;
      s_d.wp = (s_q.wp == AW'(DEPTH - 1)) ? '0 : s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = (s_q.rp == AW'(DEPTH - 1)) ? '0 : s_q.rp + 1'b1;
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

/* verilog/rlc_pkg.sv */
package rlc_pkg;
  typedef enum logic [2:0] {
    RLC_ST_IDLE    = 3'b000,
    RLC_ST_CHECK   = 3'b001,
    RLC_ST_CONFIG  = 3'b010,
    RLC_ST_INITSEQ = 3'b011,
    RLC_ST_STARTUP = 3'b100,
    RLC_ST_RUN     = 3'b101,
    RLC_ST_FAULT   = 3'b110
  } rlc_state_t;

  typedef enum logic [2:0] {
    RLC_MD_SLAVE    = 3'b000,
    RLC_MD_ASYNC    = 3'b001,
    RLC_MD_TIMER    = 3'b010,
    RLC_MD_AUTO     = 3'b011,
    RLC_MD_EXTERNAL = 3'b100,
    RLC_MD_EXTCYC   = 3'b101
  } rlc_mode_t;

  typedef struct packed {
    rlc_state_t  st;
    rlc_mode_t   mode;
    logic [7:0]  hwa;
    logic [7:0]  pend_node;
    logic [1:0]  pend_pow;
    logic        fill;
    logic [7:0]  node;
    logic [1:0]  tx_power;
    logic [15:0] timer_per;
    logic [5:0]  err;
    logic [7:0]  nodes;
    logic [7:0]  faulty;
    logic [31:0] cycles;
    logic [31:0] overruns;
    logic [31:0] timeouts;
    logic [31:0] crcs;
    logic [31:0] rdata;
    logic        irq;
    logic        cyc_start;
    logic        init_seq;
    logic [19:0] wait_cnt;
  } rlc_ctl_t;
endpackage

/* verilog/rlc_regs.svh */
`ifndef RLC_REGS_SVH
`define RLC_REGS_SVH
// Register offsets (byte addresses, one word each)
`define RLC_OFF_CTRL    8'h00
`define RLC_OFF_STATUS  8'h04
`define RLC_OFF_NODES   8'h08
`define RLC_OFF_CYCLES  8'h0c
`define RLC_OFF_OVERRUN 8'h10
`define RLC_OFF_TIMEOUT 8'h14
`define RLC_OFF_CRC     8'h18
`define RLC_OFF_FAULTY  8'h1c
`define RLC_OFF_TXDATA  8'h20
`define RLC_OFF_TIMER   8'h24
// Control field positions
`define RLC_CTRL_MODE_LSB  0
`define RLC_CTRL_START     3
`define RLC_CTRL_FILL      4
`define RLC_CTRL_POW_LSB   5
`define RLC_CTRL_NODE_LSB  8
`define RLC_CTRL_HWA_LSB   16
// Error status word bits
`define RLC_ERR_RANGE   0
`define RLC_ERR_DUP     1
`define RLC_ERR_START   2
`define RLC_ERR_TMO     3
`define RLC_ERR_CRC     4
`define RLC_ERR_OVR     5
// Permitted ranges and reset values
`define RLC_MODE_COUNT  3'h6
`define RLC_NODE_MAX    8'hc8
`define RLC_POW_MIN     2'h1
`define RLC_TIMER_RST   16'h03e8
// Timing: start-up supervision time and clock rate
`define RLC_STARTUP_US  10000
`define RLC_MCLK_MHZ    25
`endif

/* verilog/rlc_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module rlc_timer #(
  parameter int WIDTH = 16
) (
  input  wire logic             mclk_i,
  input  wire logic             reset_i,
  input  wire logic             run_i,
  input  wire logic [WIDTH-1:0] period_i,
  output logic                  tick_o
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic             tick;
  } rlc_tmr_st_t;

  rlc_tmr_st_t s_q, s_d;

  assign tick_o = s_q.tick;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!run_i) begin
      s_d.cnt = '0;
    end else if (s_q.cnt + 1'b1 >= period_i) begin
      // Period of zero behaves like one: never stalls
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire
